// file: ipg_map.svh
// Register map, field positions, reset values and timing for the
// inter-packet gap timer and its register window.
// Assumes an APB master with 32-bit data and byte addresses.
// Behaviour
// - A 7-bit back-to-back gap field sets least time between frames.
// - In half duplex, carrier during gap part one makes the transmitter defer.
// - After part one, carrier is ignored; part two ends, then transmit.
// - Gap registers take 16 and 32-bit accesses; 8-bit writes ignored.
// - Each register except state and RXOVF has clear, set, invert aliases; RXOVF reads zero and ignores writes.
// - Unimplemented gap register bits read zero, writes ignored.
`ifndef IPG_MAP_SVH
`define IPG_MAP_SVH
`define OFS_CTRL_ONE 16'h2000
`define OFS_CTRL_TWO 16'h2010
`define OFS_TX_START 16'h2020
`define OFS_RX_START 16'h2030
`define OFS_HASH_LO 16'h2040
`define OFS_HASH_HI 16'h2050
`define OFS_PMASK_LO 16'h2060
`define OFS_PMASK_HI 16'h2070
`define OFS_PCSUM 16'h2080
`define OFS_POFS 16'h2090
`define OFS_RXFC 16'h20A0
`define OFS_RXWM 16'h20B0
`define OFS_IEN 16'h20C0
`define OFS_IRQ 16'h20D0
`define OFS_STATE 16'h20E0
`define OFS_RXOVF 16'h2100
`define OFS_B2B_GAP 16'h2110
`define OFS_NB2B_GAP 16'h2120
`define OFS_MAC_CFG 16'h2130
`define ALIAS_CLR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INV 2'h3
`define B2B_RESET 32'h00000012
`define NB2B_RESET 32'h00000C12
`define B2B_MASK 32'h0000007F
`define NB2B_MASK 32'h00007F7F
`define P1_LSB 8
`define FULL_OFS 7'h03
`define HALF_OFS 7'h06
`define CFG_FULL_BIT 0
`define CFG_FAST_BIT 1
`define IRQ_TXDONE_BIT 3
`define IRQ_DEFER_BIT 4
`define IRQ_MASK 32'h00000018
`define STATE_TXBUSY_BIT 6
`define CLK_MHZ 125
`define NIB_FAST_NS 40
`define NIB_SLOW_NS 400
`define NIB_FAST_CYC (((`NIB_FAST_NS) * (`CLK_MHZ) + 999) / 1000)
`define NIB_SLOW_CYC (((`NIB_SLOW_NS) * (`CLK_MHZ) + 999) / 1000)
`endif

// file: ipg_pkg.sv
// Types shared by the gap timer.
// Assumes the map header supplies all numbers.
package ipg_pkg;
  typedef enum logic [1:0] {
    idle_state = 2'b00,
    part_one_state = 2'b01,
    part_two_state = 2'b11,
    send_state = 2'b10
  } gap_state_type;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } apb_req_type;

  typedef struct packed {
    logic req;
    logic crs;
    logic done;
  } tx_side_type;
endpackage

// file: ipg_timer.sv
// Transmit inter-packet gap timer with its APB register window.
// Assumes a synchronous frame source: tx_req held until tx_go, tx_done
// pulses at frame end; carrier comes in synchronous to clk.
//
// The APB interface to the registers is this design's own decision.
`include "ipg_map.svh"

module ipg_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit side
  input wire logic tx_req,
  input wire logic tx_done,
  input wire logic carrier,
  output logic tx_go,
  output logic tx_busy,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  ipg_pkg::apb_req_type bus;
  assign bus = '{sel: psel, en: penable, wr: pwrite, addr: paddr,
                 wdata: pwdata, strb: pstrb};

  // Base of the register word group, alias in bits 3:2
  function automatic logic [15:0] base_of(input logic [15:0] a);
    base_of = {a[15:4], 4'h0};
  endfunction

  logic [15:0] base;
  logic [1:0] alias_sel;
  logic access;
  logic byte_only;
  assign base = base_of(bus.addr);
  assign alias_sel = bus.addr[3:2];
  assign access = bus.sel && bus.en && !pready;
  // Byte writes carry one lane only; halfword and word carry two or four
  assign byte_only = (bus.strb == 4'h1) || (bus.strb == 4'h2) ||
                     (bus.strb == 4'h4) || (bus.strb == 4'h8);

  ////////////////////////////////////////////////////////////////////////
  // Register storage, indexed
  localparam int NREG = 15;
  logic [31:0] regs_q [NREG];
  logic [31:0] regs_d [NREG];
  logic [15:0] reg_ofs [NREG];
  logic [31:0] reg_mask [NREG];
  logic [31:0] reg_rst [NREG];
  assign reg_ofs = '{`OFS_CTRL_ONE, `OFS_CTRL_TWO, `OFS_TX_START,
                     `OFS_RX_START, `OFS_HASH_LO, `OFS_HASH_HI,
                     `OFS_PMASK_LO, `OFS_PMASK_HI, `OFS_PCSUM, `OFS_POFS,
                     `OFS_RXFC, `OFS_RXWM, `OFS_IEN, `OFS_B2B_GAP,
                     `OFS_NB2B_GAP};
  // Unimplemented bits masked off on store and read
  assign reg_mask = '{32'hFFFF_A393, 32'h0000_07F0, 32'hFFFF_FFFC,
                      32'hFFFF_FFFC, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF,
                      32'h0000_FFFF, 32'h0000_DFFF, 32'h00FF_00FF,
                      `IRQ_MASK, `B2B_MASK, `NB2B_MASK};
  assign reg_rst = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                     32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                     `B2B_RESET, `NB2B_RESET};

  // Alias write result: plain, clear, set or invert of ones written
  function automatic logic [31:0] alias_apply(input logic [31:0] old,
    input logic [31:0] wd, input logic [1:0] kind);
    unique case (kind)
      `ALIAS_CLR: alias_apply = old & ~wd;
      `ALIAS_SET: alias_apply = old | wd;
      `ALIAS_INV: alias_apply = old ^ wd;
      default: alias_apply = wd;
    endcase
  endfunction

  logic [NREG-1:0] hit;
  logic [31:0] rd_regs [NREG];
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      assign hit[gi] = (base == reg_ofs[gi]);
      assign rd_regs[gi] = hit[gi] ? (regs_q[gi] & reg_mask[gi]) : 32'h0;
      // Byte writes dropped so a partial lane never corrupts a field
      assign regs_d[gi] = (access && bus.wr && hit[gi] && !byte_only) ?
        (alias_apply(regs_q[gi], bus.wdata, alias_sel) & reg_mask[gi]) :
        regs_q[gi];
      always_ff @(posedge clk)
      begin
        if (rst)
          regs_q[gi] <= reg_rst[gi];
        else
          regs_q[gi] <= regs_d[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Configuration, flag and state words
  logic [6:0] b2b_value;
  logic [6:0] part_one;
  logic [6:0] part_two;
  logic full_duplex;
  logic fast_link;
  logic [31:0] cfg_q;
  logic [31:0] ien;
  assign b2b_value = regs_q[13][6:0];
  assign part_one = regs_q[14][`P1_LSB +: 7];
  assign part_two = regs_q[14][6:0];
  assign ien = regs_q[12];
  assign full_duplex = cfg_q[`CFG_FULL_BIT];
  assign fast_link = cfg_q[`CFG_FAST_BIT];

  logic hit_cfg;
  logic hit_irq;
  logic hit_state;
  logic hit_ovf;
  assign hit_cfg = (base == `OFS_MAC_CFG);
  assign hit_irq = (base == `OFS_IRQ);
  assign hit_state = (base == `OFS_STATE);
  assign hit_ovf = (base == `OFS_RXOVF);

  // Mode register, same alias scheme
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_q <= 32'h0;
    else if (access && bus.wr && hit_cfg && !byte_only)
      cfg_q <= alias_apply(cfg_q, bus.wdata, alias_sel) & 32'h3;
  end

  ////////////////////////////////////////////////////////////////////////
  // Gap sequencer
  ipg_pkg::gap_state_type st_q;
  ipg_pkg::gap_state_type st_d;
  logic [15:0] tick_q;
  logic [6:0] nib_q;
  logic prev_b2b_q;
  logic nib_tick;
  logic [15:0] tick_max;
  logic [6:0] b2b_total;
  logic [6:0] first_total;
  assign tick_max = fast_link ? 16'(`NIB_FAST_CYC - 1) :
                                16'(`NIB_SLOW_CYC - 1);
  // Compare with >= so a speed change mid-gap cannot strand the prescaler
  assign nib_tick = (tick_q >= tick_max);
  // Duplex offset added to the programmed value
  assign b2b_total = b2b_value + (full_duplex ? `FULL_OFS : `HALF_OFS);
  // Back-to-back uses one stretch; otherwise two parts
  assign first_total = prev_b2b_q ? b2b_total : part_one;

  logic defer;
  assign defer = (st_q == ipg_pkg::part_one_state) && carrier &&
                 !prev_b2b_q && !full_duplex;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ipg_pkg::idle_state:
        if (tx_req)
          st_d = ipg_pkg::part_one_state;
      ipg_pkg::part_one_state:
        if (!defer && nib_tick && nib_q + 7'h1 >= first_total)
          st_d = prev_b2b_q ? ipg_pkg::send_state :
                              ipg_pkg::part_two_state;
      // Carrier no longer looked at here
      ipg_pkg::part_two_state:
        if (nib_tick && nib_q + 7'h1 >= part_two)
          st_d = ipg_pkg::send_state;
      // A frame already waiting goes straight into the back-to-back gap
      ipg_pkg::send_state:
        if (tx_done)
          st_d = tx_req ? ipg_pkg::part_one_state :
                          ipg_pkg::idle_state;
    endcase
  end

  logic st_change;
  assign st_change = (st_d != st_q);

  // Nibble prescaler and nibble counter, restarted on defer
  always_ff @(posedge clk)
  begin
    if (rst || st_change || defer || st_q == ipg_pkg::idle_state)
      tick_q <= 16'h0;
    else
      tick_q <= nib_tick ? 16'h0 : tick_q + 16'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst || st_change || defer)
      nib_q <= 7'h0;
    else if (nib_tick)
      nib_q <= nib_q + 7'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= ipg_pkg::idle_state;
    else
      st_q <= st_d;
  end

  // Frame ended and the next is already waiting: back-to-back case
  always_ff @(posedge clk)
  begin
    if (rst)
      prev_b2b_q <= 1'b0;
    else if (st_q == ipg_pkg::send_state && tx_done)
      prev_b2b_q <= tx_req;
    else if (st_q == ipg_pkg::idle_state)
      prev_b2b_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_go <= 1'b0;
      tx_busy <= 1'b0;
    end
    else
    begin
      tx_go <= (st_d == ipg_pkg::send_state);
      tx_busy <= (st_d != ipg_pkg::idle_state);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt flags: set wins over clear; read of flags also clears
  logic [31:0] flags_q;
  logic [31:0] flag_set;
  logic [31:0] flag_keep;
  logic flag_read;
  assign flag_set = ({31'h0, st_q == ipg_pkg::send_state && tx_done}
                     << `IRQ_TXDONE_BIT) |
                    ({31'h0, defer} << `IRQ_DEFER_BIT);
  assign flag_read = access && !bus.wr && hit_irq && alias_sel == 2'h0;
  assign flag_keep = (access && bus.wr && hit_irq && !byte_only) ?
    alias_apply(flags_q, bus.wdata, alias_sel) :
    (flag_read ? 32'h0 : flags_q);

  always_ff @(posedge clk)
  begin
    if (rst)
      flags_q <= 32'h0;
    else
      flags_q <= (flag_keep | flag_set) & `IRQ_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      // Next enable value, so irq follows a mask write in the same cycle
      irq <= |((flag_keep | flag_set) & regs_d[12] & `IRQ_MASK);
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux and bus answer, one wait cycle
  logic [31:0] state_word;
  logic [31:0] rd_or;
  logic known;
  assign state_word = {25'h0, tx_busy, 6'h0} << 0;
  always_comb
  begin
    rd_or = 32'h0;
    for (int i = 0; i < NREG; i++)
      rd_or = rd_or | rd_regs[i];
  end
  assign known = (|hit) || hit_cfg || hit_irq || hit_ovf ||
                 (hit_state && alias_sel == 2'h0);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= access;
      pslverr <= access && !known;
      prdata <= (!access || bus.wr) ? 32'h0 :
                (rd_or | (hit_cfg ? cfg_q : 32'h0) |
                 (hit_irq ? flags_q : 32'h0) |
                 (hit_state ? state_word : 32'h0));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks; even all-zero settings leave at least two nibbles of gap
  b2b_gap_a: assert property
    (@(posedge clk) disable iff (rst)
    $rose(st_q == ipg_pkg::part_one_state) |-> !tx_go[*8])
    else $error("gap ended early");
  defer_hold_a: assert property
    (@(posedge clk) disable iff (rst)
    defer |=> st_q == ipg_pkg::part_one_state && nib_q == 7'h0)
    else $error("carrier did not restart part one");
  part_two_a: assert property
    (@(posedge clk) disable iff (rst)
    st_q == ipg_pkg::part_two_state |=> st_q != ipg_pkg::part_one_state)
    else $error("part two fell back on carrier");
  irq_level_a: assert property
    (@(posedge clk) disable iff (rst)
    |(flags_q & ien) |-> irq)
    else $error("unmasked flag without interrupt");
  gap_mask_a: assert property
    (@(posedge clk) disable iff (rst)
    regs_q[14][31:15] == 17'h0 && regs_q[14][7] == 1'b0)
    else $error("unimplemented gap bits set");
  byte_write_a: assert property
    (@(posedge clk) disable iff (rst)
    access && bus.wr && byte_only |=> $stable(regs_q[13]))
    else $error("byte write changed gap");
  set_alias_a: assert property
    (@(posedge clk) disable iff (rst)
    access && bus.wr && hit[13] && alias_sel == `ALIAS_SET && !byte_only
    |=> (regs_q[13] & $past(bus.wdata) & `B2B_MASK) ==
        ($past(bus.wdata) & `B2B_MASK))
    else $error("set alias missed bits");
  go_gap_a: assert property
    (@(posedge clk) disable iff (rst)
    $rose(tx_go) |-> $past(st_q) != ipg_pkg::idle_state)
    else $error("frame started with no gap");
  busy_go_a: assert property
    (@(posedge clk) disable iff (rst)
    tx_go |-> tx_busy)
    else $error("grant without busy");
  pready_pulse_a: assert property
    (@(posedge clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready stood two cycles");
  slverr_ready_a: assert property
    (@(posedge clk) disable iff (rst)
    pslverr |-> pready)
    else $error("error without ready");
endmodule

// file: phy_model.sv
// Link-side model for the gap timer: frame source, frame end and carrier.
// Assumes the bench steers it through want, crs_in and len.
module phy_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic want,
  input wire logic crs_in,
  input wire logic [7:0] len,
  // Link
  input wire logic tx_go,
  output ipg_pkg::tx_side_type side
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic sent_q;
  logic done_q;
  ////////////////////////////////////////////////////////////////////////
  // One frame of len+1 cycles per grant; done pulses once, while tx_go high
  always_ff @(posedge clk)
  begin
    done_q <= 1'b0;
    if (rst || !tx_go)
    begin
      cnt_q <= 8'h00;
      sent_q <= 1'b0;
    end
    else if (!sent_q)
    begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == len)
      begin
        done_q <= 1'b1;
        sent_q <= 1'b1;
      end
    end
  end
  // Request is held by the bench until tx_go, as the timer expects
  assign side = '{req: want, crs: crs_in, done: done_q};
endmodule

// file: ipg_timer_tb.sv
// Bench for the gap timer: APB register checks and link gap timing.
// Assumes the map header numbers and the link model in phy_model.sv.
`include "ipg_map.svh"

module ipg_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NIB = `NIB_FAST_CYC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_go, tx_busy, irq;
  logic want = 1'b0;
  logic crs = 1'b0;
  ipg_pkg::tx_side_type side;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  ////////////////////////////////////////////////////////////////////////
  // Design and link model
  ipg_timer uut
  (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_req(side.req), .tx_done(side.done), .carrier(side.crs),
    .tx_go(tx_go), .tx_busy(tx_busy), .irq(irq)
  );
  phy_model link
  (
    .clk(clk), .rst(rst), .want(want), .crs_in(crs), .len(8'h10),
    .tx_go(tx_go), .side(side)
  );
  // Clock and hang guard; the ceiling is well above the planned run
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
  begin
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
  begin
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  function automatic logic [31:0] near(input int v, input int e);
    return {31'h0, v >= e - 3 && v <= e + 3};
  endfunction
  // One APB transfer; one idle cycle after it so strobes never double up
  task automatic apb(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic [3:0] s);
  begin
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rc(input string nm, input logic [15:0] a,
    input logic [31:0] e);
  begin
    apb(1'b0, a, 32'h00000000, 4'hF);
    chk(nm, rd, e);
  end
  endtask
  // Bounded wait for the grant in wait_go; wait_low has no bound, the guard above ends a true hang
  task automatic wait_go();
  begin
    n = 0;
    while (tx_go !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  end
  endtask
  task automatic wait_low();
    while (tx_go === 1'b1)
      @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc("b2b reset", `OFS_B2B_GAP, `B2B_RESET);
    rc("nb2b reset", `OFS_NB2B_GAP, `NB2B_RESET);
    rc("flags reset", `OFS_IRQ, 32'h00000000);
    rc("state reset", `OFS_STATE, 32'h00000000);
    wr(`OFS_B2B_GAP, 32'hFFFFFFFF);
    rc("b2b unused", `OFS_B2B_GAP, `B2B_MASK);
    wr(`OFS_NB2B_GAP, 32'hFFFFFFFF);
    rc("nb2b unused", `OFS_NB2B_GAP, `NB2B_MASK);
    apb(1'b1, `OFS_B2B_GAP, 32'h00000000, 4'h1);
    rc("byte write", `OFS_B2B_GAP, `B2B_MASK);
    apb(1'b1, `OFS_B2B_GAP, 32'h00000015, 4'h3);
    rc("half write", `OFS_B2B_GAP, 32'h00000015);
    wr(`OFS_B2B_GAP + 16'h0004, 32'h00000001);
    rc("clr alias", `OFS_B2B_GAP, 32'h00000014);
    wr(`OFS_B2B_GAP + 16'h0008, 32'h00000003);
    rc("set alias", `OFS_B2B_GAP, 32'h00000017);
    wr(`OFS_B2B_GAP + 16'h000C, 32'h0000000F);
    rc("inv alias", `OFS_B2B_GAP, 32'h00000018);
    apb(1'b0, 16'h3000, 32'h00000000, 4'hF);
    chk("unmapped", {31'h0, err}, 32'h1);
    wr(`OFS_NB2B_GAP, 32'h00000C12);
    $display("test registers done");
    // Back-to-back gap in full then half duplex, both 24 nibbles
    for (int i = 0; i < 2; i++)
    begin
      wr(`OFS_MAC_CFG, i ? 32'h2 : 32'h3);
      wr(`OFS_B2B_GAP, i ? 32'h12 : 32'h15);
      want <= 1'b1;
      wait_go();
      wait_low();
      wait_go();
      chk("b2b gap", near(n, 24 * NIB), 32'h1);
      want <= 1'b0;
      wait_low();
    end
    $display("test back to back done");
    apb(1'b0, `OFS_IRQ, 32'h00000000, 4'hF);
    // Carrier in part one restarts the gap; in part two it is ignored
    crs <= 1'b1;
    want <= 1'b1;
    repeat (40) @(posedge clk);
    chk("busy defer", {31'h0, tx_busy}, 32'h1);
    crs <= 1'b0;
    wait_go();
    chk("defer", near(n, 30 * NIB), 32'h1);
    want <= 1'b0;
    wait_low();
    want <= 1'b1;
    repeat (12 * NIB + 10) @(posedge clk);
    crs <= 1'b1;
    wait_go();
    chk("late crs", near(n, 18 * NIB - 10), 32'h1);
    crs <= 1'b0;
    want <= 1'b0;
    wait_low();
    repeat (4) @(posedge clk);
    $display("test carrier done");
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`OFS_IEN, `IRQ_MASK);
    repeat (2) @(posedge clk);
    chk("irq on", {31'h0, irq}, 32'h1);
    rc("flags", `OFS_IRQ, `IRQ_MASK);
    repeat (2) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test interrupt done");
    print_verdict();
  end
endmodule
